// ==== logic/bmu_datapath.sv ====
// Bit manipulation datapath with a registered result
`timescale 1ns/1ps
module bmu_datapath
  import bmu_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             op_valid,
  input  wire bmu_pkg::bmu_op_t op,
  input  wire logic [31:0]      src_a,
  input  wire logic [31:0]      src_b,
  input  wire logic [31:0]      src_d,
  input  wire logic [4:0]       length_operand,
  input  wire logic [4:0]       position_operand,
  output      logic             result_valid,
  output      logic [31:0]      result
);
  import bmu_pkg::*;

  // Register forms take length and position from the second source
  wire        by_reg     = (op == BMU_EXTRACT_S_REG) || (op == BMU_EXTRACT_U_REG) || (op == BMU_INSERT_REG) ||
                           (op == BMU_CLEAR_REG) || (op == BMU_SET_REG);
  wire [4:0]  field_pos  = by_reg ? src_b[POS_LSB +: FIELD_W] : position_operand;
  wire [4:0]  field_len  = by_reg ? src_b[LEN_LSB +: FIELD_W] : length_operand;

  // Top of the field, capped at bit 31
  wire [5:0]  field_sum  = {1'b0, field_pos} + {1'b0, field_len};
  wire [4:0]  field_hi   = field_sum[5] ? TOP_BIT : field_sum[4:0];
  wire [31:0] field_mask = ({32{1'b1}} << field_pos) & ({32{1'b1}} >> (TOP_BIT - field_hi));

  // Extraction, aligned to bit 0
  wire [31:0] keep       = field_mask >> field_pos;
  wire        sign_bit   = src_a[field_hi];
  wire [31:0] ext_zero   = (src_a >> field_pos) & keep;
  wire [31:0] ext_sign   = ext_zero | ({32{sign_bit}} & ~keep);

  // Insert truncates at bit 31 simply by the mask, so overflowing source bits drop
  wire [31:0] ins_value  = (src_d & ~field_mask) | ((src_a << field_pos) & field_mask);
  wire [31:0] clr_value  = src_a & ~field_mask;
  wire [31:0] set_value  = src_a | field_mask;

  // Rotate uses the low five bits of the second source
  wire [4:0]  rot_amt    = src_b[4:0];
  wire [31:0] rot_value  = (src_a >> rot_amt) | (src_a << (6'h20 - {1'b0, rot_amt}));

  // Bit reverse on the pre-shifted word
  wire [31:0] shifted    = src_a << position_operand;
  wire [1:0]  grp        = (length_operand[1:0] == GRP_ALIAS) ? GRP_SINGLE : length_operand[1:0];
  logic [31:0] rev_r2;
  logic [31:0] rev_r4;
  logic [31:0] rev_r8;

  // Groups keep internal bit order; the triple form leaves bits 31:30 at zero
  genvar k;
  generate
    for (k = 0; k < 32; k++) begin : g_r2
      assign rev_r2[k] = shifted[31-k];
    end
    for (k = 0; k < 16; k++) begin : g_r4
      assign rev_r4[2*k +: 2] = shifted[30-2*k +: 2];
    end
    for (k = 0; k < 10; k++) begin : g_r8
      assign rev_r8[3*k +: 3] = shifted[29-3*k +: 3];
    end
  endgenerate
  assign rev_r8[31:30] = 2'h0;

  wire [31:0] rev_value  = (grp == GRP_PAIR) ? rev_r4 : (grp == GRP_TRIPLE) ? rev_r8 : rev_r2;

  // Counting unit
  bmu_count_if cnt_bus ();
  assign cnt_bus.operand = src_a;
  bmu_counter u_counter (
    .cnt (cnt_bus.counter)
  );

  // Result selection
  logic [31:0] next_result;
  always_comb begin
    case (op)
      BMU_EXTRACT_S, BMU_EXTRACT_S_REG: next_result = ext_sign;
      BMU_EXTRACT_U, BMU_EXTRACT_U_REG: next_result = ext_zero;
      BMU_INSERT, BMU_INSERT_REG:       next_result = ins_value;
      BMU_CLEAR, BMU_CLEAR_REG:         next_result = clr_value;
      BMU_SET, BMU_SET_REG:             next_result = set_value;
      BMU_FIRST_ONE:                    next_result = {26'h0, cnt_bus.first_one};
      BMU_LAST_ONE:                     next_result = {26'h0, cnt_bus.last_one};
      BMU_LEAD_SIGN:                    next_result = {26'h0, cnt_bus.lead_sign};
      BMU_POP_COUNT:                    next_result = {26'h0, cnt_bus.ones};
      BMU_ROTATE_RIGHT:                 next_result = rot_value;
      BMU_BIT_REVERSE:                  next_result = rev_value;
      default:                          next_result = RESULT_RST;
    endcase
  end

  // Output register; result holds when no operation is issued
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_valid <= 1'b0;
      result       <= RESULT_RST;
    end else begin
      result_valid <= op_valid;
      if (op_valid) begin
        result <= next_result;
      end
    end
  end

  // Checks, one cycle from issue to result
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_issue(bmu_op_t o);
    op_valid && (op == o);
  endsequence

  a_extract_sign: assert property (s_issue(BMU_EXTRACT_S) |=> result[31] == $past(sign_bit))
    else $error("signed extract lost field sign");
  a_extract_reg_src: assert property (s_issue(BMU_EXTRACT_U_REG) |=>
      result == (($past(src_a) >> $past(src_b[4:0])) & $past(keep)))
    else $error("register extract used wrong operand bits");
  a_clear_reg_zero: assert property (s_issue(BMU_CLEAR_REG) |=> (result & $past(field_mask)) == '0)
    else $error("register clear left field bits set");
  a_set_field_ones: assert property (s_issue(BMU_SET) |=> (result & $past(field_mask)) == $past(field_mask))
    else $error("set left field bits clear");
  a_set_pass_rest: assert property (s_issue(BMU_SET) |=>
      (result & ~$past(field_mask)) == ($past(src_a) & ~$past(field_mask)))
    else $error("set changed bits outside field");
  a_set_reg_pos: assert property (s_issue(BMU_SET_REG) |=> result[$past(src_b[4:0])] == 1'b1)
    else $error("register set missed field start");
  // The index is applied to the sampled source, not sampled itself, so it uses the current result
  a_first_one_low: assert property (s_issue(BMU_FIRST_ONE) ##0 (src_a != '0) |=>
      result < 32'h20 && ((($past(src_a) >> result[4:0]) & 32'h1) == 32'h1) &&
      (($past(src_a) & ((32'h1 << result[4:0]) - 32'h1)) == '0))
    else $error("first one index wrong");
  a_last_one_zero: assert property (s_issue(BMU_LAST_ONE) ##0 (src_a == '0) |=> result == 32'h20)
    else $error("last one of zero not 32");
  a_lead_sign_zero: assert property (s_issue(BMU_LEAD_SIGN) ##0 (src_a == '0) |=> result == '0)
    else $error("leading sign count of zero not 0");
  a_pop_count: assert property (s_issue(BMU_POP_COUNT) |=> result == 32'($countones($past(src_a))))
    else $error("population count wrong");
  a_rotate_wrap: assert property (s_issue(BMU_ROTATE_RIGHT) |=>
      result[31 - $past(src_b[4:0])] == $past(src_a[31]))
    else $error("rotate misplaced top bit");
  a_alias_single: assert property (s_issue(BMU_BIT_REVERSE) ##0 (length_operand[1:0] == GRP_ALIAS) |=>
      result == $past(rev_r2))
    else $error("group size 3 not single bit reverse");
  a_field_width: assert property (op_valid && (field_sum < 6'h20) |->
      $countones(field_mask) == int'(field_len) + 1)
    else $error("field width not length plus one");
  a_clear_imm: assert property (s_issue(BMU_CLEAR) |=> result == ($past(src_a) & ~$past(field_mask)))
    else $error("immediate clear wrong");
  a_pair_reverse: assert property (s_issue(BMU_BIT_REVERSE) ##0 (length_operand[1:0] == GRP_PAIR) |=>
      result[1:0] == $past(shifted[31:30]))
    else $error("pair reverse misordered");
  a_shift_discard: assert property (s_issue(BMU_BIT_REVERSE) ##0 ((length_operand[1:0] == GRP_SINGLE) &&
      (position_operand != '0)) |=> result[31] == 1'b0)
    else $error("pre-shift did not discard bits");
  a_insert_low: assert property (s_issue(BMU_INSERT) |=> result[$past(field_pos)] == $past(src_a[0]) &&
      (result & ~$past(field_mask)) == ($past(src_d) & ~$past(field_mask)))
    else $error("insert placed field wrongly");
endmodule

// ==== logic/bmu_pkg.sv ====
// Shared constants and operation codes for the bit manipulation unit
package bmu_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned FIELD_W     = 5;
  localparam int unsigned COUNT_W     = 6;
  localparam logic [4:0]  TOP_BIT     = 5'h1f;
  // Register operand field positions
  localparam int unsigned POS_LSB     = 0;
  localparam int unsigned LEN_LSB     = 5;
  // Value reported when no bit is found
  localparam logic [5:0]  NONE_FOUND  = 6'h20;
  // Reset values
  localparam logic [31:0] RESULT_RST  = 32'h0000_0000;
  // Bit reverse group sizes
  localparam logic [1:0]  GRP_SINGLE  = 2'h0;
  localparam logic [1:0]  GRP_PAIR    = 2'h1;
  localparam logic [1:0]  GRP_TRIPLE  = 2'h2;
  localparam logic [1:0]  GRP_ALIAS   = 2'h3;

  typedef enum logic [3:0] {
    BMU_EXTRACT_S     = 4'h0,
    BMU_EXTRACT_U     = 4'h1,
    BMU_EXTRACT_S_REG = 4'h2,
    BMU_EXTRACT_U_REG = 4'h3,
    BMU_INSERT        = 4'h4,
    BMU_INSERT_REG    = 4'h5,
    BMU_CLEAR         = 4'h6,
    BMU_CLEAR_REG     = 4'h7,
    BMU_SET           = 4'h8,
    BMU_SET_REG       = 4'h9,
    BMU_FIRST_ONE     = 4'ha,
    BMU_LAST_ONE      = 4'hb,
    BMU_LEAD_SIGN     = 4'hc,
    BMU_POP_COUNT     = 4'hd,
    BMU_ROTATE_RIGHT  = 4'he,
    BMU_BIT_REVERSE   = 4'hf
  } bmu_op_t;
endpackage

// ==== logic/bmu_count_if.sv ====
// Carrier between the datapath and its bit counting unit
`timescale 1ns/1ps
interface bmu_count_if;
  logic [31:0] operand;
  logic [5:0]  first_one;
  logic [5:0]  last_one;
  logic [5:0]  lead_sign;
  logic [5:0]  ones;
  modport client  (output operand, input first_one, input last_one, input lead_sign, input ones);
  modport counter (input operand, output first_one, output last_one, output lead_sign, output ones);
endinterface

// ==== logic/bmu_counter.sv ====
// Bit scanning and counting logic of the bit manipulation unit
`timescale 1ns/1ps
module bmu_counter
  import bmu_pkg::*;
(
  bmu_count_if.counter cnt
);
  // Leading zeros, NONE_FOUND for an all-zero word
  function automatic logic [5:0] lead_zeros(input logic [31:0] v);
    logic [5:0] n;
    n = NONE_FOUND;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        n = 6'(31 - i);
      end
    end
    return n;
  endfunction

  // Trailing zeros, NONE_FOUND for an all-zero word
  function automatic logic [5:0] trail_zeros(input logic [31:0] v);
    logic [5:0] n;
    n = NONE_FOUND;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        n = 6'(i);
      end
    end
    return n;
  endfunction

  wire        is_zero   = (cnt.operand == '0);
  // Bits equal to the sign become zeros, so one scan serves both signs
  wire [31:0] sign_norm = cnt.operand ^ {32{cnt.operand[31]}};
  wire [5:0]  lz_plain  = lead_zeros(cnt.operand);
  wire [5:0]  lz_sign   = lead_zeros(sign_norm);

  // Scan and count results
  assign cnt.first_one = trail_zeros(cnt.operand);
  assign cnt.last_one  = is_zero ? NONE_FOUND : 6'(31 - lz_plain);
  assign cnt.lead_sign = is_zero ? 6'h00 : lz_sign - 6'h01;
  assign cnt.ones      = 6'($countones(cnt.operand));
endmodule

// ==== testbench/tb_bit_manipulation_unit.sv ====
// Self-checking bench for the bit manipulation unit datapath
`timescale 1ns/1ps
module tb_bit_manipulation_unit;
  import bmu_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        op_valid;
  bmu_op_t     op;
  logic [31:0] src_a;
  logic [31:0] src_b;
  logic [31:0] src_d;
  logic [4:0]  length_operand;
  logic [4:0]  position_operand;
  logic        result_valid;
  logic [31:0] result;
  logic [31:0] last_exp;
  int          miscompares;
  int          check_count;
  logic [31:0] vals [5] = '{32'hc64a5933, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0001, 32'h0000_8000};

  bmu_datapath u_dut (.clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op(op), .src_a(src_a),
    .src_b(src_b), .src_d(src_d), .length_operand(length_operand), .position_operand(position_operand),
    .result_valid(result_valid), .result(result));

  // Free-running 25 MHz clock
  always #20 clk = ~clk;

  // Reference behaviour, worked out bit by bit rather than by masks alone
  function automatic logic [31:0] model(bmu_op_t o, logic [31:0] a, logic [31:0] b, logic [31:0] d,
                                        logic [4:0] l, logic [4:0] p);
    logic [63:0] m;
    logic [31:0] s;
    logic [31:0] r;
    int          hi;
    int          w;
    r = 32'h0;
    if (o inside {BMU_EXTRACT_S_REG, BMU_EXTRACT_U_REG, BMU_INSERT_REG, BMU_CLEAR_REG, BMU_SET_REG}) begin
      l = b[9:5];
      p = b[4:0];
    end
    hi = (int'(p) + int'(l) > 31) ? 31 : int'(p) + int'(l);
    m = ((64'h1 << (hi - int'(p) + 1)) - 64'h1) << p;
    s = a << p;
    w = (l[1:0] == 2'h3) ? 1 : int'(l[1:0]) + 1;
    case (o)
      BMU_EXTRACT_S, BMU_EXTRACT_S_REG, BMU_EXTRACT_U, BMU_EXTRACT_U_REG: begin
        r = (a & m[31:0]) >> p;
        if (o inside {BMU_EXTRACT_S, BMU_EXTRACT_S_REG} && a[hi])
          r = r | ~(m[31:0] >> p);
      end
      BMU_INSERT, BMU_INSERT_REG: r = (d & ~m[31:0]) | ((a << p) & m[31:0]);
      BMU_CLEAR, BMU_CLEAR_REG:   r = a & ~m[31:0];
      BMU_SET, BMU_SET_REG:       r = a | m[31:0];
      BMU_FIRST_ONE: begin
        r = 32'h20;
        for (int i = 31; i >= 0; i--) if (a[i]) r = 32'(i);
      end
      BMU_LAST_ONE: begin
        r = 32'h20;
        for (int i = 0; i < 32; i++) if (a[i]) r = 32'(i);
      end
      BMU_LEAD_SIGN: begin
        for (int i = 30; i >= 0 && a[i] == a[31]; i--) r = r + 32'h1;
        if (a == 32'h0) r = 32'h0;
      end
      BMU_POP_COUNT:    r = 32'($countones(a));
      BMU_ROTATE_RIGHT: r = 32'({a, a} >> b[4:0]);
      default: begin
        for (int k = 0; k < 32 / w; k++)
          for (int j = 0; j < w; j++) r[w * k + j] = s[32 - w * (k + 1) + j];
      end
    endcase
    return r;
  endfunction

  task automatic check32(logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask

  // Issue one op and judge it one edge later; valid stays up so calls run back to back
  task automatic issue(bmu_op_t o, logic [31:0] a, logic [31:0] b, logic [31:0] d, logic [4:0] l, logic [4:0] p);
    last_exp = model(o, a, b, d, l, p);
    op_valid = 1'b1;
    op = o;
    src_a = a;
    src_b = b;
    src_d = d;
    length_operand = l;
    position_operand = p;
    @(posedge clk);
    #1;
    check32(32'h1, {31'h0, result_valid});
    check32(last_exp, result);
  endtask

  // Idle cycle: pulse must end and the result must hold
  task automatic idle();
    op_valid = 1'b0;
    @(posedge clk);
    #1;
    check32(32'h0, {31'h0, result_valid});
    check32(last_exp, result);
  endtask

  task automatic t_extract();
    foreach (vals[i]) begin
      issue(BMU_EXTRACT_S, vals[i], 32'h0, 32'h0, 5'h07, 5'h1c);
      issue(BMU_EXTRACT_U, vals[i], 32'h0, 32'h0, 5'h03, 5'h05);
      issue(BMU_EXTRACT_S_REG, vals[i], 32'hffff_fc6a, 32'h0, 5'h0, 5'h0);
      issue(BMU_EXTRACT_U_REG, vals[i], 32'h0000_0088, 32'h0, 5'h1f, 5'h1f);
    end
    idle();
  endtask

  task automatic t_insert();
    foreach (vals[i]) begin
      issue(BMU_INSERT, vals[i], 32'h0, 32'h5a5a_a5a5, 5'h09, 5'h1a);
      issue(BMU_INSERT_REG, vals[i], 32'h0000_0063, 32'h5a5a_a5a5, 5'h0, 5'h0);
    end
    idle();
  endtask

  task automatic t_clear_set();
    foreach (vals[i]) begin
      issue(BMU_CLEAR, vals[i], 32'h0, 32'h0, 5'h04, 5'h02);
      issue(BMU_CLEAR_REG, vals[i], 32'h0000_03ff, 32'h0, 5'h0, 5'h0);
      issue(BMU_SET, vals[i], 32'h0, 32'h0, 5'h1f, 5'h00);
      issue(BMU_SET, vals[i], 32'h0, 32'h0, 5'h02, 5'h1e);
      issue(BMU_SET_REG, vals[i], 32'hffff_8021, 32'h0, 5'h0, 5'h0);
    end
    idle();
  endtask

  task automatic t_counts();
    foreach (vals[i]) begin
      issue(BMU_FIRST_ONE, vals[i], 32'h0, 32'h0, 5'h0, 5'h0);
      issue(BMU_LAST_ONE, vals[i], 32'h0, 32'h0, 5'h0, 5'h0);
      issue(BMU_LEAD_SIGN, vals[i], 32'h0, 32'h0, 5'h0, 5'h0);
      issue(BMU_POP_COUNT, vals[i], 32'h0, 32'h0, 5'h0, 5'h0);
      issue(BMU_ROTATE_RIGHT, vals[i], 32'hffff_ffe0, 32'h0, 5'h0, 5'h0);
      issue(BMU_ROTATE_RIGHT, vals[i], 32'h0000_0021, 32'h0, 5'h0, 5'h0);
      issue(BMU_ROTATE_RIGHT, vals[i], 32'h0000_001f, 32'h0, 5'h0, 5'h0);
    end
    idle();
  endtask

  task automatic t_reverse();
    for (int g = 0; g < 4; g++) begin
      issue(BMU_BIT_REVERSE, 32'hc64a5933, 32'h0, 32'h0, {3'h7, 2'(g)}, 5'h00);
      issue(BMU_BIT_REVERSE, 32'hc64a5933, 32'h0, 32'h0, {3'h0, 2'(g)}, 5'h04);
    end
    issue(BMU_BIT_REVERSE, 32'hc64a5933, 32'h0, 32'h0, 5'h03, 5'h09);
    issue(BMU_BIT_REVERSE, 32'hc64a5933, 32'h0, 32'h0, 5'h02, 5'h04);
    check32(32'h216b244b, result);
    idle();
  endtask

  // Reset in mid-run clears both outputs at once, without a clock edge
  task automatic t_reset();
    issue(BMU_SET, 32'h0, 32'h0, 32'h0, 5'h1f, 5'h0);
    op_valid = 1'b0;
    reset_n = 1'b0;
    last_exp = 32'h0;
    #5;
    check32(32'h0, {31'h0, result_valid});
    check32(32'h0, result);
    @(posedge clk);
    #1;
    reset_n = 1'b1;
    idle();
    // First request after a mid-run release must be taken normally
    issue(BMU_POP_COUNT, 32'hc64a5933, 32'h0, 32'h0, 5'h0, 5'h0);
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence; inputs move 1 ns after the rising edge
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    op_valid = 1'b0;
    op = BMU_EXTRACT_S;
    {src_a, src_b, src_d, length_operand, position_operand} = '0;
    last_exp = 32'h0;
    miscompares = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    idle();
    t_extract();
    t_insert();
    t_clear_set();
    t_counts();
    t_reverse();
    t_reset();
    close_out();
  end

  // Watchdog: about 100 ops expected, so 2000 cycles is ample
  initial begin
    #(40 * 2000);
    miscompares++;
    close_out();
  end
endmodule
